/* File: logic/timer16_map.svh */
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH
// ------------------------------------------------------------
// register offsets (word index on the register port)
// ------------------------------------------------------------
`define OFS_COUNTER     4'h0
`define OFS_COMPARE_A   4'h1
`define OFS_COMPARE_B   4'h2
`define OFS_MODE        4'h3
`define OFS_CC_CTRL     4'h4
`define OFS_OUT_CTRL    4'h5
`define OFS_PRESCALE    4'h6
`define OFS_STATUS      4'h7
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define MODE_SEL_LO     2
`define MODE_SEL_HI     3
`define OC_ENABLE_BIT   0
`define OC_TOGGLE_BIT   1
`define OC_ONESHOT_BIT  2
`define OC_SWTRIG_BIT   6
`define PR_CLK_LO       0
`define PR_CLK_HI       1
`define PR_EDGE_LO      4
`define PR_EDGE_HI      5
`define ST_OVF_BIT      0
// ------------------------------------------------------------
// reset values and counts
// ------------------------------------------------------------
`define RST_REG16       16'h0000
`define ALL_ONES16      16'hFFFF
`define DIV4_LAST       4'h3
`define DIV16_LAST      4'hF
`endif

/* File: logic/timer16_pkg.sv */
package timer16_pkg;
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;
  typedef enum logic [1:0] {
    MODE_STOP, MODE_EDGE_CLEAR, MODE_FREE_RUN, MODE_MATCH_CLEAR
  } mode_sel_type;
  typedef enum logic [1:0] {
    CLK_DIV1, CLK_DIV4, CLK_DIV16, CLK_INPUT_EDGE
  } clk_sel_type;
  typedef enum logic [1:0] {
    EDGE_FALL, EDGE_RISE, EDGE_NONE, EDGE_BOTH
  } edge_sel_type;
  typedef enum logic [1:0] {
    OS_IDLE, OS_FIRST, OS_SECOND
  } os_state_type;
endpackage : timer16_pkg

/* File: logic/timer16_wave_oneshot.sv */
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "timer16_map.svh"
// Function
// RULE1 - event counting: count each selected edge, clear and interrupt on compare A
// RULE2 - input pin sampled on system clock, valid only after two equal samples
// RULE3 - clear-on-A event counting sets overflow only when compare A is all ones
// RULE4 - software reads the event count from the main counter
// RULE5 - enable and toggle bits set: invert output every compare A plus one ticks
// RULE6 - software does not rewrite compare A during square-wave running
// RULE7 - software keeps compare A nonzero when clearing on compare A match
// RULE8 - software programs setup and nonzero compares, writes mode last
// RULE9 - software trigger bit clears the counter and restarts counting
// RULE10 - with B below A, output goes active at B, inactive at A
// RULE11 - with B above A, active at A, inactive at B; never equal
// RULE12 - counter keeps running after the pulse until mode set to stop
// RULE13 - software waits for a match interrupt before triggering again
// RULE14 - input edge also triggers one-shot while software trigger is used
// RULE15 - edge select field picks rising, falling or both edges
// RULE16 - selected input edge in one-shot clears and starts the counter
// RULE17 - further input edges ignored while a pulse is in progress
// RULE18 - counter runs whenever mode select is not the stop code
// RULE19 - first match after start may come up to one count tick late
// RULE20 - compare contents need not survive a stop
// RULE21 - software changes edge select only while stopped
// RULE22 - match A and match B interrupts on every match, one-shot included
module timer16_wave_oneshot (
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire timer16_pkg::reg_req_type  reg_req,
  output logic [15:0]                    reg_rdata,
  input  wire logic                      timer_input_a,
  output logic                           timer_output_pin,
  output logic                           match_a_interrupt,
  output logic                           match_b_interrupt,
  output logic                           counter_overflow_flag
);

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic [15:0]                main_up_counter;
  logic [15:0]                compare_a;
  logic [15:0]                compare_b;
  logic [15:0]                timer_mode_register;
  logic [15:0]                capture_compare_control;
  logic [15:0]                output_control_register;
  logic [15:0]                prescaler_edge_register;
  logic [15:0]                rdata_r;
  logic                       ovf_r;
  logic                       out_r;
  logic                       irq_a_r;
  logic                       irq_b_r;
  logic [3:0]                 div_r;
  logic                       sync1_r;
  logic                       sync2_r;
  logic                       samp_r;
  logic                       stable_r;
  timer16_pkg::os_state_type  os_r;

  logic                       wr_hit_mode;
  logic                       running;
  timer16_pkg::mode_sel_type  mode_sel;
  timer16_pkg::clk_sel_type   clk_sel;
  timer16_pkg::edge_sel_type  edge_sel;
  logic                       out_enable;
  logic                       toggle_en;
  logic                       oneshot_en;
  logic                       sw_trig;
  logic                       valid_lvl;
  logic                       rise_det;
  logic                       fall_det;
  logic                       sel_edge;
  logic                       div_tick;
  logic                       count_en;
  logic                       restart;
  logic                       match_a;
  logic                       match_b;
  logic                       first_is_b;
  logic                       first_hit;
  logic                       second_hit;
  logic                       ovf_set;
  logic                       ovf_clr;

  assign wr_hit_mode = reg_req.wr && reg_req.addr == `OFS_MODE;
  assign mode_sel    = timer16_pkg::mode_sel_type'(
                         timer_mode_register[`MODE_SEL_HI:`MODE_SEL_LO]);
  assign running     = mode_sel != timer16_pkg::MODE_STOP; // RULE18
  assign clk_sel     = timer16_pkg::clk_sel_type'(
                         prescaler_edge_register[`PR_CLK_HI:`PR_CLK_LO]);
  assign edge_sel    = timer16_pkg::edge_sel_type'(
                         prescaler_edge_register[`PR_EDGE_HI:`PR_EDGE_LO]);
  assign out_enable  = output_control_register[`OC_ENABLE_BIT];
  assign toggle_en   = output_control_register[`OC_TOGGLE_BIT];
  assign oneshot_en  = output_control_register[`OC_ONESHOT_BIT];
  assign sw_trig     = reg_req.wr && reg_req.addr == `OFS_OUT_CTRL
                       && reg_req.wdata[`OC_SWTRIG_BIT]; // RULE9

  // compares are simply held over a stop; nothing depends on that
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      compare_a <= `RST_REG16;
      compare_b <= `RST_REG16;
    end
    else if (reg_req.wr)
    begin
      if (reg_req.addr == `OFS_COMPARE_A)
        compare_a <= reg_req.wdata; // RULE20
      if (reg_req.addr == `OFS_COMPARE_B)
        compare_b <= reg_req.wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      timer_mode_register <= `RST_REG16;
    else if (wr_hit_mode)
      timer_mode_register <= reg_req.wdata;
  end

  // trigger bit is an action, never stored
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      capture_compare_control <= `RST_REG16;
      output_control_register <= `RST_REG16;
      prescaler_edge_register <= `RST_REG16;
    end
    else if (reg_req.wr)
    begin
      if (reg_req.addr == `OFS_CC_CTRL)
        capture_compare_control <= reg_req.wdata;
      if (reg_req.addr == `OFS_OUT_CTRL)
      begin
        output_control_register <= reg_req.wdata;
        output_control_register[`OC_SWTRIG_BIT] <= 1'b0;
      end
      if (reg_req.addr == `OFS_PRESCALE)
        prescaler_edge_register <= reg_req.wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      rdata_r <= `RST_REG16;
    else if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        `OFS_COUNTER:   rdata_r <= main_up_counter;
        `OFS_COMPARE_A: rdata_r <= compare_a;
        `OFS_COMPARE_B: rdata_r <= compare_b;
        `OFS_MODE:      rdata_r <= timer_mode_register;
        `OFS_CC_CTRL:   rdata_r <= capture_compare_control;
        `OFS_OUT_CTRL:  rdata_r <= output_control_register;
        `OFS_PRESCALE:  rdata_r <= prescaler_edge_register;
        `OFS_STATUS:    rdata_r <= {13'h0000, os_r != timer16_pkg::OS_IDLE,
                                    out_r, ovf_r};
        default:        rdata_r <= `RST_REG16;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

  // ------------------------------------------------------------
  // input pin sampling and edge detection
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sync1_r  <= 1'b0;
      sync2_r  <= 1'b0;
      samp_r   <= 1'b0;
      stable_r <= 1'b0;
    end
    else
    begin
      sync1_r <= timer_input_a;
      sync2_r <= sync1_r;
      samp_r  <= sync2_r;
      // tracked while stopped too, so a high pin gives no edge on re-enable
      if (valid_lvl)
        stable_r <= sync2_r;
    end
  end

  assign valid_lvl = sync2_r == samp_r; // RULE2
  assign rise_det  = valid_lvl && sync2_r && !stable_r;
  assign fall_det  = valid_lvl && !sync2_r && stable_r;
  // RULE15
  assign sel_edge  = running &&
                     ((rise_det && (edge_sel == timer16_pkg::EDGE_RISE ||
                                    edge_sel == timer16_pkg::EDGE_BOTH)) ||
                      (fall_det && (edge_sel == timer16_pkg::EDGE_FALL ||
                                    edge_sel == timer16_pkg::EDGE_BOTH)));

  // ------------------------------------------------------------
  // count clock
  // ------------------------------------------------------------
  // divider free-runs, so a start lands anywhere inside a tick period
  always_ff @(posedge core_clk)
  begin
    if (reset)
      div_r <= 4'h0;
    else
      div_r <= div_r + 4'h1; // RULE19
  end

  always_comb
  begin
    unique case (clk_sel)
      timer16_pkg::CLK_DIV1:       div_tick = 1'b1;
      timer16_pkg::CLK_DIV4:       div_tick = div_r[1:0] == `DIV4_LAST;
      timer16_pkg::CLK_DIV16:      div_tick = div_r == `DIV16_LAST;
      timer16_pkg::CLK_INPUT_EDGE: div_tick = sel_edge; // RULE1
    endcase
  end

  assign count_en = running && div_tick;

  // ------------------------------------------------------------
  // counter, matches, restart
  // ------------------------------------------------------------
  // RULE14 RULE16 RULE17
  assign restart = running &&
                   ((oneshot_en && (sw_trig ||
                     (sel_edge && os_r == timer16_pkg::OS_IDLE))) ||
                    (!oneshot_en && sel_edge &&
                     mode_sel == timer16_pkg::MODE_EDGE_CLEAR));
  assign match_a = count_en && !restart && main_up_counter == compare_a;
  assign match_b = count_en && !restart && main_up_counter == compare_b;

  always_ff @(posedge core_clk)
  begin
    if (reset)
      main_up_counter <= `RST_REG16;
    else if (!running)
      main_up_counter <= `RST_REG16;
    else if (restart)
      main_up_counter <= `RST_REG16; // RULE9
    else if (match_a && mode_sel == timer16_pkg::MODE_MATCH_CLEAR)
      main_up_counter <= `RST_REG16; // RULE1
    else if (count_en)
      main_up_counter <= main_up_counter + 16'h0001; // RULE12
  end

  // all-ones rollover; in clear-on-A only reachable with A all ones
  assign ovf_set = count_en && !restart && main_up_counter == `ALL_ONES16; // RULE3
  assign ovf_clr = reg_req.wr && reg_req.addr == `OFS_STATUS &&
                   reg_req.wdata[`ST_OVF_BIT];

  // set beats a clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (reset)
      ovf_r <= 1'b0;
    else if (ovf_set)
      ovf_r <= 1'b1;
    else if (ovf_clr)
      ovf_r <= 1'b0;
  end

  assign counter_overflow_flag = ovf_r;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      irq_a_r <= 1'b0;
      irq_b_r <= 1'b0;
    end
    else
    begin
      irq_a_r <= match_a; // RULE22
      irq_b_r <= match_b; // RULE22
    end
  end

  assign match_a_interrupt = irq_a_r;
  assign match_b_interrupt = irq_b_r;

  // ------------------------------------------------------------
  // one-shot sequencing and output
  // ------------------------------------------------------------
  assign first_is_b = compare_b < compare_a;
  // RULE10 RULE11
  assign first_hit  = first_is_b ? match_b : match_a;
  assign second_hit = first_is_b ? match_a : match_b;

  always_ff @(posedge core_clk)
  begin
    if (reset || !running || !oneshot_en)
      os_r <= timer16_pkg::OS_IDLE;
    else if (restart)
      os_r <= timer16_pkg::OS_FIRST;
    else
    begin
      unique case (os_r)
        timer16_pkg::OS_IDLE:   os_r <= timer16_pkg::OS_IDLE;
        timer16_pkg::OS_FIRST:  if (first_hit) os_r <= timer16_pkg::OS_SECOND;
        timer16_pkg::OS_SECOND: if (second_hit) os_r <= timer16_pkg::OS_IDLE;
        default:                os_r <= timer16_pkg::OS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset || !out_enable)
      out_r <= 1'b0;
    else if (oneshot_en)
    begin
      if (restart)
        out_r <= 1'b0;
      else if (os_r == timer16_pkg::OS_FIRST && first_hit)
        out_r <= 1'b1; // RULE10 RULE11
      else if (os_r == timer16_pkg::OS_SECOND && second_hit)
        out_r <= 1'b0; // RULE10 RULE11
    end
    else if (toggle_en && match_a)
      out_r <= !out_r; // RULE5
  end

  assign timer_output_pin = out_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_match_clears_count: assert property ( // RULE1
    match_a && mode_sel == timer16_pkg::MODE_MATCH_CLEAR && !wr_hit_mode
    |=> main_up_counter == 16'h0000 && match_a_interrupt)
    else $error("compare A match did not clear counter");

  a_edge_counts_up: assert property ( // RULE1
    count_en && clk_sel == timer16_pkg::CLK_INPUT_EDGE && !restart && !match_a
    && !wr_hit_mode
    |=> main_up_counter == $past(main_up_counter) + 16'h0001)
    else $error("input edge did not advance counter");

  a_edge_needs_twice: assert property ( // RULE2
    sel_edge |-> $past(sync2_r) == sync2_r && sync2_r != stable_r)
    else $error("edge accepted without two equal samples");

  a_ovf_all_ones: assert property ( // RULE3
    !ovf_r ##1 ovf_r && mode_sel == timer16_pkg::MODE_MATCH_CLEAR
    |-> $past(compare_a) == 16'hFFFF)
    else $error("overflow set with compare A not all ones");

  a_toggle_on_a: assert property ( // RULE5
    match_a && out_enable && toggle_en && !oneshot_en && !reg_req.wr
    |=> out_r != $past(out_r))
    else $error("square wave did not toggle on match");

  a_sw_restart: assert property ( // RULE9
    sw_trig && oneshot_en && running && !wr_hit_mode
    |=> main_up_counter == 16'h0000 && os_r == timer16_pkg::OS_FIRST)
    else $error("software trigger did not restart");

  a_pulse_rises: assert property ( // RULE10
    os_r == timer16_pkg::OS_FIRST && first_hit && out_enable && !reg_req.wr
    |=> out_r && os_r == timer16_pkg::OS_SECOND)
    else $error("one-shot did not go active");

  a_pulse_falls: assert property ( // RULE11
    os_r == timer16_pkg::OS_SECOND && second_hit && !restart && !reg_req.wr
    |=> !out_r && os_r == timer16_pkg::OS_IDLE)
    else $error("one-shot did not go inactive");

  a_busy_ignores_edge: assert property ( // RULE17
    oneshot_en && os_r != timer16_pkg::OS_IDLE && !sw_trig |-> !restart)
    else $error("trigger taken during pulse");

  a_stop_holds_zero: assert property ( // RULE18
    !running [*2] |-> main_up_counter == 16'h0000 && !match_a)
    else $error("counter moved while stopped");

  c_square_toggle: cover property (match_a && toggle_en && out_enable);
  c_oneshot_done:  cover property (os_r == timer16_pkg::OS_SECOND && second_hit);
  c_overflow:      cover property (ovf_set);
  c_ext_trigger:   cover property (sel_edge && oneshot_en && restart);

endmodule : timer16_wave_oneshot

/* File: testbench/timer16_wave_oneshot_tb.sv */
`timescale 1ns/1ps
`include "timer16_map.svh"
module timer16_wave_oneshot_tb;
  logic                     core_clk;
  logic                     reset;
  timer16_pkg::reg_req_type reg_req;
  logic [15:0]              reg_rdata;
  logic                     timer_input_a;
  logic                     timer_output_pin;
  logic                     match_a_interrupt;
  logic                     match_b_interrupt;
  logic                     counter_overflow_flag;
  int                       mismatches = 0;
  int                       total_checks = 0;
  int                       cyc = 0;
  int                       cnt_a = 0;
  int                       cnt_b = 0;
  int                       a_prev = 0;
  int                       a_gap = 0;
  int                       ca;
  int                       cb;
  int                       w;
  logic [15:0]              rv;
  logic [15:0]              rv2;
  logic                     act;
  logic [15:0]              nv [2] = '{16'h0004, 16'h000A};
  logic [15:0]              mv [2] = '{16'h000A, 16'h0004};
  logic [15:0]              es [3] = '{16'h0010, 16'h0000, 16'h0030};

  timer16_wave_oneshot u_timer16_wave_oneshot (
    .core_clk              (core_clk),
    .reset                 (reset),
    .reg_req               (reg_req),
    .reg_rdata             (reg_rdata),
    .timer_input_a         (timer_input_a),
    .timer_output_pin      (timer_output_pin),
    .match_a_interrupt     (match_a_interrupt),
    .match_b_interrupt     (match_b_interrupt),
    .counter_overflow_flag (counter_overflow_flag)
  );

  // ------------------------------------------------------------
  // clock, interrupt monitor, hang guard
  // ------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ceiling: overflow wait dominates, the rest is a few hundred cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (match_a_interrupt === 1'b1)
    begin
      cnt_a++;
      a_gap = cyc - a_prev;
      a_prev = cyc;
    end
    if (match_b_interrupt === 1'b1)
      cnt_b++;
    if (cyc == 90000)
    begin
      mismatches++;
      final_report();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic final_report();
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // n edges seen at falling clock edges until the pin reaches lvl
  task automatic wait_lvl(input logic lvl, output int n);
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (timer_output_pin !== lvl && n < 3000);
  endtask : wait_lvl

  task automatic pin(input logic v, input int n);
    @(posedge core_clk);
    timer_input_a <= v;
    repeat (n - 1) @(posedge core_clk);
  endtask : pin

  task automatic pulse();
    pin(1'b1, 4);
    pin(1'b0, 6);
  endtask : pulse

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    timer_input_a = 1'b0;
    reg_req = '0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    rd(`OFS_COUNTER, rv);
    check("counter_reset", rv, 16'h0000);
    rd(`OFS_STATUS, rv);
    check("status_reset", rv, 16'h0000);
    rd(4'h8, rv);
    check("unmapped_read", rv, 16'h0000);
    wr(`OFS_COMPARE_A, 16'h1234);
    rd(`OFS_COMPARE_A, rv);
    check("compare_a_rw", rv, 16'h1234);
    wr(`OFS_COUNTER, 16'h5555);
    rd(`OFS_COUNTER, rv);
    check("counter_read_only", rv, 16'h0000);
    // square wave at divide by 1 and divide by 4
    for (int d = 0; d < 2; d++)
    begin
      wr(`OFS_MODE, 16'h0000);
      wr(`OFS_PRESCALE, 16'h0020 | d[15:0]);
      wr(`OFS_COMPARE_A, 16'h0003);
      wr(`OFS_OUT_CTRL, 16'h0003);
      wr(`OFS_MODE, 16'h000C);
      wait_lvl(1'b1, w);
      wait_lvl(1'b0, w);
      check("half_period", w[15:0], 16'h0004 << (2 * d));
      // the monitor counts the pulse one edge after the pin moves
      @(negedge core_clk);
      check("match_a_gap", a_gap[15:0], 16'h0004 << (2 * d));
    end
    wr(`OFS_OUT_CTRL, 16'h0002);
    repeat (4) @(negedge core_clk);
    check("output_disabled", {15'h0000, timer_output_pin}, 16'h0000);
    // event counting on rising edges, glitch first, then on both edges
    wr(`OFS_MODE, 16'h0000);
    wr(`OFS_PRESCALE, 16'h0013);
    wr(`OFS_COMPARE_A, 16'h0005);
    wr(`OFS_MODE, 16'h000C);
    pin(1'b1, 1);
    pin(1'b0, 6);
    rd(`OFS_COUNTER, rv);
    check("glitch_ignored", rv, 16'h0000);
    ca = cnt_a;
    repeat (5) pulse();
    rd(`OFS_COUNTER, rv);
    check("event_count", rv, 16'h0005);
    pulse();
    rd(`OFS_COUNTER, rv);
    check("event_clear", rv, 16'h0000);
    check("event_match_a", 16'(cnt_a - ca), 16'h0001);
    check("no_overflow", {15'h0000, counter_overflow_flag}, 16'h0000);
    wr(`OFS_MODE, 16'h0000);
    wr(`OFS_PRESCALE, 16'h0033);
    wr(`OFS_COMPARE_A, 16'h0009);
    wr(`OFS_MODE, 16'h000C);
    repeat (2) pulse();
    rd(`OFS_COUNTER, rv);
    check("both_edges", rv, 16'h0004);
    // clear on each rising input edge; three clocks from pin to edge
    wr(`OFS_MODE, 16'h0000);
    wr(`OFS_PRESCALE, 16'h0010);
    wr(`OFS_MODE, 16'h0004);
    pulse();
    rd(`OFS_COUNTER, rv);
    check("edge_clear", rv, 16'h0006);
    // overflow only with compare a all ones; long wait, divide by 1
    wr(`OFS_MODE, 16'h0000);
    wr(`OFS_PRESCALE, 16'h0020);
    wr(`OFS_COMPARE_A, 16'hFFFF);
    wr(`OFS_MODE, 16'h000C);
    repeat (65560) @(negedge core_clk);
    check("overflow_set", {15'h0000, counter_overflow_flag}, 16'h0001);
    wr(`OFS_STATUS, 16'h0001);
    rd(`OFS_STATUS, rv);
    check("overflow_cleared", rv & 16'h0001, 16'h0000);
    // software one-shot, B below A then B above A
    for (int i = 0; i < 2; i++)
    begin
      wr(`OFS_MODE, 16'h0000);
      wr(`OFS_PRESCALE, 16'h0020);
      wr(`OFS_COMPARE_B, nv[i]);
      wr(`OFS_COMPARE_A, mv[i]);
      wr(`OFS_OUT_CTRL, 16'h0005);
      wr(`OFS_MODE, 16'h0008);
      ca = cnt_a;
      cb = cnt_b;
      wr(`OFS_OUT_CTRL, 16'h0045);
      wait_lvl(1'b1, w);
      wait_lvl(1'b0, w);
      check("sw_pulse_width", w[15:0], 16'h0006);
      @(negedge core_clk);
      check("sw_match_a", 16'(cnt_a - ca), 16'h0001);
      check("sw_match_b", 16'(cnt_b - cb), 16'h0001);
      rd(`OFS_COUNTER, rv);
      rd(`OFS_COUNTER, rv2);
      check("keeps_counting", rv2 - rv, 16'h0002);
    end
    wr(`OFS_MODE, 16'h0000);
    rd(`OFS_COUNTER, rv);
    check("stopped_counter", rv, 16'h0000);
    // external trigger: rising, falling, both; re-edges inside the pulse
    for (int i = 0; i < 3; i++)
    begin
      act = (es[i] != 16'h0000);
      wr(`OFS_MODE, 16'h0000);
      pin(~act, 8);
      wr(`OFS_PRESCALE, es[i]);
      wr(`OFS_COMPARE_B, 16'h0004);
      wr(`OFS_COMPARE_A, 16'h0028);
      wr(`OFS_OUT_CTRL, 16'h0005);
      wr(`OFS_MODE, 16'h0008);
      repeat (8) @(posedge core_clk);
      fork
        begin
          wait_lvl(1'b1, w);
          wait_lvl(1'b0, w);
        end
        begin
          pin(act, 12);
          pin(~act, 6);
          pin(act, 6);
        end
      join
      check("ext_pulse_width", w[15:0], 16'h0024);
    end
    final_report();
  end
endmodule : timer16_wave_oneshot_tb
